/* File: rtl/spmbc_defs.vh */
// register offsets, field positions and reset values of the buffered spi master
`ifndef SPMBC_DEFS_VH
`define SPMBC_DEFS_VH

`define SPMBC_OFF_STATUS      12'h000
`define SPMBC_OFF_COMMAND     12'h008
`define SPMBC_OFF_RX_BUF      12'h00c
`define SPMBC_OFF_RX_CRC      12'h010
`define SPMBC_OFF_TX_BUF      12'h014
`define SPMBC_OFF_TX_CRC      12'h018
`define SPMBC_OFF_CRC_RES     12'h01c
`define SPMBC_OFF_THRESH      12'h020
`define SPMBC_OFF_MAP         12'h02c
`define SPMBC_OFF_FLAGS       12'h034
`define SPMBC_OFF_FLAG_CLR    12'h038

`define SPMBC_CMD_RX_GO       0
`define SPMBC_CMD_RX_SEED     1
`define SPMBC_CMD_TX_GO       2
`define SPMBC_CMD_TX_SEED     3

`define SPMBC_LEN_LSB         14
`define SPMBC_ADDR_LSB        0
`define SPMBC_SKIP_LSB        8
`define SPMBC_SEED_LSB        0
`define SPMBC_APPEND_BIT      17
`define SPMBC_CRC_TX_LSB      8
`define SPMBC_CRC_RX_LSB      0
`define SPMBC_REG_START_LSB   16
`define SPMBC_REG_SIZE_LSB    0
`define SPMBC_FLAG_WL_BIT     2

`define SPMBC_RST_SKIP        9'h001
`define SPMBC_RST_SEED        8'hff
`define SPMBC_RST_CRC         8'hff
`define SPMBC_RST_APPEND      1'b1
`define SPMBC_RST_SIZE        14'h2fff

`define SPMBC_RAM_BASE        32'h0010_0000
`define SPMBC_CRC_POLY        8'h07
`define SPMBC_RX_FILL         8'hff

`endif

/* File: rtl/spmbc_fifo.v */
// synchronous valid/ready fifo with registered read data
module spmbc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             flush,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output reg              out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0]    wp_r;
	reg [AW-1:0]    rp_r;
	reg [AW:0]      cnt_r;
	wire            push;
	wire            pop;
	wire            load;

	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign push     = in_valid & in_ready;
	// output register refills whenever it is empty or being taken
	assign pop      = (cnt_r != {(AW+1){1'b0}}) & (~out_valid | out_ready);
	assign load     = pop;

	always @(posedge pclk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_r      <= {AW{1'b0}};
			rp_r      <= {AW{1'b0}};
			cnt_r     <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data  <= {WIDTH{1'b0}};
		end else if (flush) begin
			wp_r      <= {AW{1'b0}};
			rp_r      <= {AW{1'b0}};
			cnt_r     <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (load) begin
				rp_r      <= rp_r + 1'b1;
				out_data  <= mem_r[rp_r];
				out_valid <= 1'b1;
			end else if (out_ready)
				out_valid <= 1'b0;
			cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
		end
	end
endmodule // spmbc_fifo

/* File: rtl/spmbc_top.v */
// transfer control of the ram-buffered spi master: registers, dma, crc, shifter
//
// Summary of operation
// - writing one to send-go starts a transmit; bit reads back zero
// - writing one to receive-go with send-go zero starts a receive; bit reads back zero
// - transmit seed command loads transmit crc from the transmit seed
// - receive seed command loads receive crc from the receive seed
// - transmit count 1 to 511; zero only with crc append enabled
// - append bit (reset one) sends crc after payload; zero count sends only crc
// - leading bytes given by skip field, reset one, stay out of the crc
// - eight-bit seeds reset to ff and apply only on seed command
// - read-only crc result: transmit in 15:8, receive in 7:0, reset ff
// - byte count in frame reaching nonzero threshold raises the level event
// - every ram access address is ram base plus region start plus buffer address and byte index
// - start commands are ignored while either direction is busy
// - level event sets flag bit 2; writing one clears it, zero no effect
`include "spmbc_defs.vh"
module spmbc_top #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         mem_req,
	output reg         mem_we,
	output reg  [31:0] mem_addr,
	output reg  [7:0]  mem_wdata,
	input  wire [7:0]  mem_rdata,
	input  wire        mem_ack,
	input  wire        spi_sck,
	input  wire        spi_miso,
	output reg         spi_mosi,
	output reg         spi_ss_n,
	output reg         send_busy_flag,
	output reg         recv_busy_flag,
	output reg         level_flag
);
	// one byte through the crc, eight serial steps, msb first
	function [7:0] crc8_byte;
		input [7:0] crc;
		input [7:0] data;
		integer     i;
		reg [7:0]   c;
		begin
			c = crc;
			for (i = 7; i >= 0; i = i - 1)
				c = {c[6:0], 1'b0} ^
				    ((c[7] ^ data[i]) ? `SPMBC_CRC_POLY : 8'h00);
			crc8_byte = c;
		end
	endfunction

	reg  [8:0]  rx_len_r;
	reg  [13:0] rx_addr_r;
	reg  [8:0]  rx_skip_r;
	reg  [7:0]  rx_seed_r;
	reg  [8:0]  tx_len_r;
	reg  [13:0] tx_addr_r;
	reg         send_crc_append;
	reg  [8:0]  tx_skip_r;
	reg  [7:0]  tx_seed_r;
	reg  [7:0]  send_crc_current;
	reg  [7:0]  recv_crc_current;
	reg  [8:0]  byte_threshold_level;
	reg  [13:0] region_start_r;
	reg  [13:0] region_size_r;
	reg  [8:0]  fidx_r, sidx_r;
	reg         stg_valid_r;
	reg  [7:0]  stg_data_r;
	reg         sh_act_r;
	reg  [2:0]  bitc_r;
	reg  [7:0]  sh_r;
	reg  [7:0]  tx_byte_r;
	reg         crc_phase_r, crc_done_r;
	reg         sck_s1_r, sck_s2_r, sck_s3_r;
	reg         miso_s1_r, miso_s2_r;
	wire        wr_en, rd_setup, busy;
	wire        sck_rise, sck_fall;
	wire [7:0]  rx_byte, fifo_in_data, fifo_out_data;
	wire        fifo_in_ready, fifo_out_valid, fifo_out_ready;
	wire        tx_load, crc_load, rx_load;
	wire        byte_done, store_pop, lvl_hit;
	wire [13:0] buf_addr;
	reg  [31:0] rdata_nxt;
	reg         err_nxt;

	assign wr_en    = psel & penable & pwrite & pready;
	assign rd_setup = psel & ~penable & ~pready;
	assign busy     = send_busy_flag | recv_busy_flag;
	assign sck_rise = sck_s2_r & ~sck_s3_r;
	assign sck_fall = ~sck_s2_r & sck_s3_r;
	assign rx_byte  = {sh_r[6:0], miso_s2_r};
	assign byte_done = sh_act_r & sck_rise & (bitc_r == 3'd7);
	assign lvl_hit   = byte_done & ~crc_phase_r &
	                   (byte_threshold_level != 9'h000) &
	                   (sidx_r + 9'd1 == byte_threshold_level);
	// shifter stalls on an empty fifo (send) or a full staging slot (receive)
	assign tx_load  = send_busy_flag & ~sh_act_r & (sidx_r < tx_len_r) &
	                  fifo_out_valid;
	assign crc_load = send_busy_flag & ~sh_act_r & (sidx_r == tx_len_r) &
	                  send_crc_append & ~crc_done_r;
	assign rx_load  = recv_busy_flag & ~sh_act_r & (sidx_r < rx_len_r) &
	                  ~stg_valid_r & ~byte_done;
	assign store_pop = recv_busy_flag & ~mem_req & fifo_out_valid;
	assign fifo_out_ready = send_busy_flag ? tx_load : store_pop;
	assign fifo_in_data   = stg_data_r;
	assign buf_addr = send_busy_flag ? tx_addr_r : rx_addr_r;

	spmbc_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.flush     (~busy),
		.in_valid  (stg_valid_r),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	always @* begin
		rdata_nxt = 32'h0000_0000;
		err_nxt   = 1'b0;
		case (paddr)
		`SPMBC_OFF_STATUS:
			rdata_nxt = {30'h0, send_busy_flag, recv_busy_flag};
		`SPMBC_OFF_COMMAND:
			rdata_nxt = 32'h0000_0000;
		`SPMBC_OFF_RX_BUF:
			rdata_nxt = {9'h0, rx_len_r, rx_addr_r};
		`SPMBC_OFF_RX_CRC:
			rdata_nxt = {15'h0, rx_skip_r, rx_seed_r};
		`SPMBC_OFF_TX_BUF:
			rdata_nxt = {9'h0, tx_len_r, tx_addr_r};
		`SPMBC_OFF_TX_CRC:
			rdata_nxt = {14'h0, send_crc_append, tx_skip_r, tx_seed_r};
		`SPMBC_OFF_CRC_RES:
			rdata_nxt = {16'h0, send_crc_current, recv_crc_current};
		`SPMBC_OFF_THRESH:
			rdata_nxt = {23'h0, byte_threshold_level};
		`SPMBC_OFF_MAP:
			rdata_nxt = {2'h0, region_start_r, 2'h0, region_size_r};
		`SPMBC_OFF_FLAGS:
			rdata_nxt = {29'h0, level_flag, 2'h0};
		`SPMBC_OFF_FLAG_CLR:
			rdata_nxt = 32'h0000_0000;
		default:
			err_nxt = 1'b1;
		endcase
	end

	// apb answers one cycle after setup: no wait states beyond that
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (rd_setup) begin
			pready  <= 1'b1;
			pslverr <= err_nxt;
			prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// link pins cross into pclk through two flops each; sck takes a third for edge detection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s1_r  <= 1'b0;
			sck_s2_r  <= 1'b0;
			sck_s3_r  <= 1'b0;
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
		end else begin
			sck_s1_r  <= spi_sck;
			sck_s2_r  <= sck_s1_r;
			sck_s3_r  <= sck_s2_r;
			miso_s1_r <= spi_miso;
			miso_s2_r <= miso_s1_r;
		end
	end

	// configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_len_r             <= 9'h000;
			rx_addr_r            <= 14'h0000;
			rx_skip_r            <= `SPMBC_RST_SKIP;
			rx_seed_r            <= `SPMBC_RST_SEED;
			tx_len_r             <= 9'h000;
			tx_addr_r            <= 14'h0000;
			send_crc_append      <= `SPMBC_RST_APPEND;
			tx_skip_r            <= `SPMBC_RST_SKIP;
			tx_seed_r            <= `SPMBC_RST_SEED;
			byte_threshold_level <= 9'h000;
			region_start_r       <= 14'h0000;
			region_size_r        <= `SPMBC_RST_SIZE;
		end else if (wr_en) begin
			case (paddr)
			`SPMBC_OFF_RX_BUF: begin
				rx_len_r  <= pwdata[`SPMBC_LEN_LSB +: 9];
				rx_addr_r <= pwdata[`SPMBC_ADDR_LSB +: 14];
			end
			`SPMBC_OFF_RX_CRC: begin
				rx_skip_r <= pwdata[`SPMBC_SKIP_LSB +: 9];
				rx_seed_r <= pwdata[`SPMBC_SEED_LSB +: 8];
			end
			`SPMBC_OFF_TX_BUF: begin
				tx_len_r  <= pwdata[`SPMBC_LEN_LSB +: 9];
				tx_addr_r <= pwdata[`SPMBC_ADDR_LSB +: 14];
			end
			`SPMBC_OFF_TX_CRC: begin
				send_crc_append <= pwdata[`SPMBC_APPEND_BIT];
				tx_skip_r       <= pwdata[`SPMBC_SKIP_LSB +: 9];
				tx_seed_r       <= pwdata[`SPMBC_SEED_LSB +: 8];
			end
			`SPMBC_OFF_THRESH:
				byte_threshold_level <= pwdata[8:0];
			`SPMBC_OFF_MAP: begin
				region_start_r <= pwdata[`SPMBC_REG_START_LSB +: 14];
				region_size_r  <= pwdata[`SPMBC_REG_SIZE_LSB +: 14];
			end
			default: ;
			endcase
		end
	end

	// transfer engine: busy flags, ram side, shifter, crc, level flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			send_busy_flag   <= 1'b0;
			recv_busy_flag   <= 1'b0;
			level_flag       <= 1'b0;
			send_crc_current <= `SPMBC_RST_CRC;
			recv_crc_current <= `SPMBC_RST_CRC;
			fidx_r           <= 9'h000;
			sidx_r           <= 9'h000;
			stg_valid_r      <= 1'b0;
			stg_data_r       <= 8'h00;
			mem_req          <= 1'b0;
			mem_we           <= 1'b0;
			mem_addr         <= 32'h0000_0000;
			mem_wdata        <= 8'h00;
			sh_act_r         <= 1'b0;
			bitc_r           <= 3'd0;
			sh_r             <= 8'h00;
			tx_byte_r        <= 8'h00;
			crc_phase_r      <= 1'b0;
			crc_done_r       <= 1'b0;
			spi_mosi         <= 1'b0;
			spi_ss_n         <= 1'b1;
		end else begin
			spi_ss_n <= ~busy;
			if (stg_valid_r & fifo_in_ready)
				stg_valid_r <= 1'b0;
			// ram side: fetch for send, store for receive
			if (mem_req) begin
				if (mem_ack) begin
					mem_req <= 1'b0;
					fidx_r  <= fidx_r + 9'd1;
					if (!mem_we) begin
						stg_valid_r <= 1'b1;
						stg_data_r  <= mem_rdata;
					end
				end
			end else if (send_busy_flag & ~stg_valid_r &
			             (fidx_r < tx_len_r)) begin
				mem_req  <= 1'b1;
				mem_we   <= 1'b0;
				mem_addr <= `SPMBC_RAM_BASE + {18'h0, region_start_r} +
				            {18'h0, buf_addr} + {23'h0, fidx_r};
			end else if (store_pop) begin
				mem_req   <= 1'b1;
				mem_we    <= 1'b1;
				mem_wdata <= fifo_out_data;
				mem_addr  <= `SPMBC_RAM_BASE + {18'h0, region_start_r} +
				             {18'h0, buf_addr} + {23'h0, fidx_r};
			end
			// shifter: mosi moves on falling sck, miso taken on rising sck
			if (tx_load | crc_load | rx_load) begin
				sh_act_r    <= 1'b1;
				bitc_r      <= 3'd0;
				crc_phase_r <= crc_load;
				sh_r        <= tx_load ? fifo_out_data :
				               crc_load ? send_crc_current : `SPMBC_RX_FILL;
				tx_byte_r   <= fifo_out_data;
				spi_mosi    <= tx_load ? fifo_out_data[7] :
				               crc_load ? send_crc_current[7] : 1'b1;
			end else if (sh_act_r & sck_rise) begin
				sh_r   <= rx_byte;
				bitc_r <= bitc_r + 3'd1;
			end else if (sh_act_r & sck_fall & (bitc_r != 3'd0))
				spi_mosi <= sh_r[7];
			if (byte_done) begin
				sh_act_r <= 1'b0;
				if (crc_phase_r)
					crc_done_r <= 1'b1;
				else begin
					sidx_r <= sidx_r + 9'd1;
					if (lvl_hit)
						level_flag <= 1'b1;
					if (send_busy_flag) begin
						if (sidx_r >= tx_skip_r)
							send_crc_current <=
								crc8_byte(send_crc_current, tx_byte_r);
					end else begin
						stg_valid_r <= 1'b1;
						stg_data_r  <= rx_byte;
						if (sidx_r >= rx_skip_r)
							recv_crc_current <=
								crc8_byte(recv_crc_current, rx_byte);
					end
				end
			end
			// completion; zero count without append simply ends at once
			if (send_busy_flag & ~sh_act_r & (sidx_r == tx_len_r) &
			    (~send_crc_append | crc_done_r))
				send_busy_flag <= 1'b0;
			if (recv_busy_flag & ~mem_req & ~stg_valid_r &
			    (fidx_r == rx_len_r) & ~fifo_out_valid)
				recv_busy_flag <= 1'b0;
			// software commands come last so a seed write wins over an update
			if (wr_en && paddr == `SPMBC_OFF_COMMAND) begin
				if (pwdata[`SPMBC_CMD_TX_SEED])
					send_crc_current <= tx_seed_r;
				if (pwdata[`SPMBC_CMD_RX_SEED])
					recv_crc_current <= rx_seed_r;
				if (!busy) begin
					fidx_r      <= 9'h000;
					sidx_r      <= 9'h000;
					crc_done_r  <= 1'b0;
					stg_valid_r <= 1'b0;
					if (pwdata[`SPMBC_CMD_TX_GO])
						send_busy_flag <= 1'b1;
					else if (pwdata[`SPMBC_CMD_RX_GO])
						recv_busy_flag <= 1'b1;
				end
			end
			// a level event in the clearing cycle keeps the flag set
			if (wr_en && paddr == `SPMBC_OFF_FLAG_CLR &&
			    pwdata[`SPMBC_FLAG_WL_BIT] && !lvl_hit)
				level_flag <= 1'b0;
		end
	end
endmodule // spmbc_top

/* File: testbench/spmbc_checker.sv */
// port-level assertions for the buffered spi master transfer control
`include "spmbc_defs.vh"
module spmbc_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        mem_req,
	input wire        mem_we,
	input wire [31:0] mem_addr,
	input wire        mem_ack,
	input wire        send_busy_flag,
	input wire        recv_busy_flag,
	input wire        level_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && pready;
	wire cmd_wr = acc && pwrite && paddr == `SPMBC_OFF_COMMAND;
	wire idle = !send_busy_flag && !recv_busy_flag;
	wire clr_wr = acc && pwrite && paddr == `SPMBC_OFF_FLAG_CLR && pwdata[2];
	property p_tx_go;
		cmd_wr && pwdata[2] && idle |-> ##[1:3] send_busy_flag;
	endproperty
	a_tx_go: assert property (p_tx_go)
		else $error("send start not taken");
	property p_rx_go;
		cmd_wr && pwdata[0] && !pwdata[2] && idle |-> ##[1:3] recv_busy_flag;
	endproperty
	a_rx_go: assert property (p_rx_go)
		else $error("receive start not taken");
	// a receive start during a send must leave the receive side idle
	property p_ignore;
		cmd_wr && send_busy_flag && !recv_busy_flag |=> !recv_busy_flag;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("start taken while busy");
	property p_cmd_rd;
		acc && !pwrite && paddr == `SPMBC_OFF_COMMAND |-> prdata == 32'h0;
	endproperty
	a_cmd_rd: assert property (p_cmd_rd)
		else $error("command bits read back nonzero");
	property p_crc_rd;
		acc && !pwrite && paddr == `SPMBC_OFF_CRC_RES |-> prdata[31:16] == 0;
	endproperty
	a_crc_rd: assert property (p_crc_rd)
		else $error("crc result upper bits nonzero");
	property p_base;
		mem_req |-> mem_addr[31:16] == 16'h0010;
	endproperty
	a_base: assert property (p_base)
		else $error("ram address outside ram window");
	property p_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
	endproperty
	a_hold: assert property (p_hold)
		else $error("ram request changed before ack");
	property p_clr;
		clr_wr && idle |=> !level_flag;
	endproperty
	a_clr: assert property (p_clr)
		else $error("level flag not cleared");
	property p_sticky;
		level_flag && !clr_wr |=> level_flag;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("level flag dropped by itself");
endmodule // spmbc_checker

bind spmbc_top spmbc_checker spmbc_checker_inst (.*);

/* File: testbench/spmbc_partner.sv */
// ram and spi slave model on the far side of the transfer control
module spmbc_partner (
	input  wire        pclk,
	input  wire        mem_req,
	input  wire        mem_we,
	input  wire [31:0] mem_addr,
	input  wire [7:0]  mem_wdata,
	output logic [7:0] mem_rdata,
	output logic       mem_ack,
	output logic       spi_sck,
	output logic       spi_miso,
	input  wire        spi_mosi,
	input  wire        spi_ss_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [int unsigned];
	logic [7:0] got_q [$];
	logic [7:0] miso_q [$];
	logic [1:0] dly = 0;
	logic [7:0] sh, tx;
	initial begin
		mem_ack = 0;
		mem_rdata = 0;
		spi_sck = 0;
		spi_miso = 0;
	end
	// wait count follows the address so prompt and slow acks both occur
	always @(posedge pclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			dly <= dly + 2'd1;
			if (dly == mem_addr[1:0]) begin
				mem_ack <= 1'b1;
				dly <= 0;
				if (mem_we)
					mem[mem_addr] = mem_wdata;
				else
					mem_rdata <= mem[mem_addr];
			end
		end
	end
	// sck only runs inside a frame; the gap lets the next byte load
	always begin
		wait (spi_ss_n === 1'b0);
		// off the pclk edge, but each byte shifts sck by 25 ns, so every fourth byte of a frame moves in a sampling time step
		#1625;
		// a frame that closed during the gap gets no further clocks
		if (spi_ss_n === 1'b0) begin
			tx = miso_q.size() ? miso_q.pop_front() : 8'hff;
			for (int i = 7; i >= 0; i--) begin
				spi_miso = tx[i];
				#400 spi_sck = 1'b1;
				sh = {sh[6:0], spi_mosi};
				#400 spi_sck = 1'b0;
			end
			got_q.push_back(sh);
			spi_miso = ~spi_miso;
		end
	end
endmodule // spmbc_partner

/* File: testbench/tb.sv */
// self-checking bench for the buffered spi master transfer control
`include "spmbc_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic        er;
	wire  [31:0] prdata, mem_addr;
	wire  [7:0]  mem_wdata, mem_rdata;
	wire         pready, pslverr, mem_req, mem_we, mem_ack, spi_sck;
	wire         spi_miso, spi_mosi, spi_ss_n, send_busy_flag;
	wire         recv_busy_flag, level_flag;
	int          n_fail = 0, cmp_count = 0, seed = 10;
	logic [7:0]  exp_q [$];
	logic [7:0]  crc, b;
	logic [8:0]  len;
	logic [11:0] ra [8] = '{`SPMBC_OFF_RX_BUF, `SPMBC_OFF_RX_CRC,
		`SPMBC_OFF_TX_BUF, `SPMBC_OFF_TX_CRC, `SPMBC_OFF_CRC_RES,
		`SPMBC_OFF_THRESH, `SPMBC_OFF_MAP, `SPMBC_OFF_COMMAND};
	logic [31:0] rv [8] = '{32'h0, 32'h1ff, 32'h0, 32'h201ff, 32'hffff,
		32'h0, 32'h2fff, 32'h0};
	spmbc_top spmbc_top_inst (.*);
	spmbc_partner spmbc_partner_inst (.*);
	always #50 pclk = ~pclk;
	function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		return c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one psel-low cycle between transfers keeps each signal single-driven
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (n >= 20)
			n_fail++;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic await(input bit t, input logic v, input int lim);
		int n;
		n = 0;
		while ((t ? send_busy_flag : recv_busy_flag) !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk(t ? send_busy_flag : recv_busy_flag, v);
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#2000000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 8; i++) begin
			apb(0, ra[i], 0);
			chk(rd, rv[i]);
		end
		apb(1, `SPMBC_OFF_CRC_RES, 32'h0);
		apb(0, `SPMBC_OFF_CRC_RES, 0);
		chk(rd, 32'hffff);
		apb(0, 12'h03c, 0);
		chk(er, 1'b1);
		apb(1, `SPMBC_OFF_MAP, 32'h0010_1fff);
		for (int k = 0; k < 3; k++) begin
			len = k ? 9'd3 + 9'($random(seed) & 3) : 9'd0;
			crc = 8'ha5;
			exp_q = {};
			for (int i = 0; i < len; i++) begin
				b = $random(seed);
				spmbc_partner_inst.mem[32'h0010_0030 + i] = b;
				exp_q.push_back(b);
				if (i >= 1)
					crc = crc8(crc, b);
			end
			if (k < 2)
				exp_q.push_back(crc);
			apb(1, `SPMBC_OFF_TX_BUF, {9'h0, len, 14'h0020});
			// the last pass runs with append off: payload only, no crc byte
			apb(1, `SPMBC_OFF_TX_CRC,
			    k < 2 ? 32'h0002_01a5 : 32'h0000_01a5);
			apb(1, `SPMBC_OFF_COMMAND, 32'h8);
			apb(0, `SPMBC_OFF_CRC_RES, 0);
			chk(rd[15:8], 8'ha5);
			spmbc_partner_inst.got_q = {};
			apb(1, `SPMBC_OFF_COMMAND, 32'h4);
			await(1, 1, 10);
			apb(0, `SPMBC_OFF_STATUS, 0);
			chk(rd, 32'h2);
			apb(1, `SPMBC_OFF_COMMAND, 32'h1);
			await(1, 0, 20000);
			chk(recv_busy_flag, 1'b0);
			chk(level_flag, 1'b0);
			chk(spmbc_partner_inst.got_q.size(), exp_q.size());
			foreach (exp_q[i])
				chk(spmbc_partner_inst.got_q[i], exp_q[i]);
			apb(0, `SPMBC_OFF_CRC_RES, 0);
			chk(rd[15:8], crc);
		end
		apb(1, `SPMBC_OFF_RX_BUF, {9'h0, 9'd3, 14'h0040});
		apb(1, `SPMBC_OFF_RX_CRC, 32'h0000_005a);
		apb(1, `SPMBC_OFF_THRESH, 32'h2);
		apb(1, `SPMBC_OFF_COMMAND, 32'h2);
		crc = 8'h5a;
		exp_q = {};
		for (int i = 0; i < 3; i++) begin
			b = $random(seed);
			spmbc_partner_inst.miso_q.push_back(b);
			exp_q.push_back(b);
			crc = crc8(crc, b);
		end
		apb(1, `SPMBC_OFF_COMMAND, 32'h1);
		await(0, 1, 10);
		apb(0, `SPMBC_OFF_STATUS, 0);
		chk(rd, 32'h1);
		await(0, 0, 20000);
		foreach (exp_q[i])
			chk(spmbc_partner_inst.mem[32'h0010_0050 + i], exp_q[i]);
		apb(0, `SPMBC_OFF_CRC_RES, 0);
		chk(rd[7:0], crc);
		chk(level_flag, 1'b1);
		apb(1, `SPMBC_OFF_FLAG_CLR, 32'h0);
		apb(0, `SPMBC_OFF_FLAGS, 0);
		chk(rd, 32'h4);
		apb(1, `SPMBC_OFF_FLAG_CLR, 32'h4);
		apb(0, `SPMBC_OFF_FLAGS, 0);
		chk(rd, 32'h0);
		tally_and_finish();
	end
endmodule // tb
